// ===== cpu_model.sv
// Bus master model that issues register cycles to the register bank
`timescale 1ns/100ps
module cpu_model
  import qdc_regs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic wr,
  output logic rd,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial wr = 1'b0;
  initial rd = 1'b0;
  initial addr = 16'h0000;
  initial wdata = 16'h0000;

  // One strobe cycle; released data is inverted so a stale value never looks valid
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : write

  // Read data is taken in the cycle after the strobe edge
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rvalid ? rdata : 16'hXXXX;
  endtask : read

  // Software never programs a window count above the maximum
  task automatic set_window(input logic [9:0] n);
    write(ADDR_ABORT_WINDOW, {6'h00, (n > WINDOW_MAX_N) ? WINDOW_MAX_N : n});
  endtask : set_window

  // Address, upper, lower; writes stay in the lower half, away from the read side
  task automatic memtest(input logic [15:0] a, input logic [31:0] w);
    write(ADDR_MEMTEST_ADDR, a & 16'h7FFF);
    write(ADDR_MEMTEST_UPPER, w[31:16]);
    write(ADDR_MEMTEST_LOWER, w[15:0]);
  endtask : memtest
endmodule : cpu_model

// ===== qdc_readout_mode_test_regs.sv
// Readout pointer stepping, abort window, mode bits, memory test and test event regs
//
// Contract
// - Any write to event step register jumps read pointer to next event.
// - Any write to word step register moves read pointer one word forward.
// - Auto advance bit clear: steps only on writes; set: steps on reads.
// - Abort window lasts 7 us plus count times 1/32 us.
// - Mode set writes set bits written as one; reads return mode word.
// - Mode clear writes clear bits written as one; zeros do nothing.
// - Mode bit 0 enables direct memory test writes into output buffer.
// - Offline bit set stops all conversions in the converter controller.
// - Data flush bit holds a data reset of buffer, pointers and counter.
// - Overrange check bit clear stores only conversions without overflow.
// - Threshold check bit clear stores only conversions at or above channel threshold.
// - Acquisition test bit feeds buffer from the internal test FIFO.
// - Slide enable clear holds the scale; separate bit disables subtraction.
// - Threshold scaled by 16 when step bit clear, by 2 when set.
// - Empty event stores header and end word only when bit is set.
// - Event counter counts all triggers or only accepted ones.
// - Address, then upper, then lower half; lower write commits word.
// - Crate number is loaded by software and goes into every data word.
// - Test event writes fill a 32 word FIFO of 16 bit words.
`timescale 1ns/100ps
module qdc_readout_mode_test_regs (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  // Readout pointer control
  input wire logic OBUF_READ,
  output logic PTR_EVENT_STEP,
  output logic PTR_WORD_STEP,
  // Abort window
  input wire logic ABORT_START,
  output logic ABORT_WINDOW_OPEN,
  // Mode outputs
  output qdc_regs_pkg::mode_t MODE,
  output logic CONV_ENABLE,
  output logic DATA_RESET,
  output logic SLIDE_HOLD,
  output logic SLIDE_SUB_OFF,
  // Conversion filter
  input wire logic CONV_VALID,
  input wire logic [11:0] CONV_VALUE,
  input wire logic CONV_OVERFLOW,
  input wire logic [7:0] CONV_THRESHOLD,
  output logic CONV_STORE,
  // Event end and trigger
  input wire logic EVENT_DONE,
  input wire logic EVENT_HAS_DATA,
  output logic EMPTY_EVENT_STORE,
  input wire logic TRIGGER,
  input wire logic TRIGGER_ACCEPTED,
  output logic EVCNT_INC,
  // Memory test write
  output logic MEMTEST_WR,
  output qdc_regs_pkg::memtest_wr_t MEMTEST,
  // Crate number
  output logic [7:0] CRATE_NUM,
  // Synthetic event stream
  output logic SYNTH_VALID,
  input wire logic SYNTH_READY,
  output logic [15:0] SYNTH_DATA
);
  import qdc_regs_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // Assert at once, release two edges later
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Abort window end, in quarter nanoseconds
  function automatic logic [17:0] window_qns(input logic [9:0] n);
    window_qns = 18'(WINDOW_BASE_QNS) + 18'(n) * 18'(WINDOW_STEP_QNS);
  endfunction : window_qns

  // Zero suppression and overflow acceptance of one conversion
  function automatic logic accept_conv(input mode_t m, input logic [11:0] v,
                                       input logic ov, input logic [7:0] thr);
    logic [11:0] limit;
    logic thr_ok;
    logic ov_ok;
    limit = m.threshold_scale_bit ? (12'(thr) << FINE_SHIFT) : (12'(thr) << COARSE_SHIFT);
    thr_ok = m.threshold_check_disable_bit || (v >= limit);
    ov_ok = m.overrange_check_disable || !ov;
    accept_conv = thr_ok && ov_ok;
  endfunction : accept_conv

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_event_step;
  logic wr_word_step;
  logic wr_window;
  logic wr_set;
  logic wr_clear;
  logic wr_mt_addr;
  logic wr_mt_upper;
  logic wr_mt_lower;
  logic wr_crate;
  logic wr_synth;

  // One strobe per register
  assign wr_event_step = REG_WR && (REG_ADDR == ADDR_EVENT_STEP);
  assign wr_word_step = REG_WR && (REG_ADDR == ADDR_WORD_STEP);
  assign wr_window = REG_WR && (REG_ADDR == ADDR_ABORT_WINDOW);
  assign wr_set = REG_WR && (REG_ADDR == ADDR_MODE_SET);
  assign wr_clear = REG_WR && (REG_ADDR == ADDR_MODE_CLEAR);
  assign wr_mt_addr = REG_WR && (REG_ADDR == ADDR_MEMTEST_ADDR);
  assign wr_mt_upper = REG_WR && (REG_ADDR == ADDR_MEMTEST_UPPER);
  assign wr_mt_lower = REG_WR && (REG_ADDR == ADDR_MEMTEST_LOWER);
  assign wr_crate = REG_WR && (REG_ADDR == ADDR_CRATE);
  assign wr_synth = REG_WR && (REG_ADDR == ADDR_SYNTH_EVENT);

  // ----------------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------------
  mode_t mode_reg;

  // Set beats clear when one write could hit both (it cannot, one address)
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      mode_reg <= mode_t'(MODE_RESET);
    else if (wr_set)
      mode_reg <= mode_t'(mode_reg | REG_WDATA);
    else if (wr_clear)
      mode_reg <= mode_t'(mode_reg & ~REG_WDATA);
  end

  // Mode fanout to the converter and scale logic
  assign MODE = mode_reg;
  assign CONV_ENABLE = !mode_reg.offline;
  assign DATA_RESET = mode_reg.data_flush;
  assign SLIDE_HOLD = !mode_reg.slide_enable;
  assign SLIDE_SUB_OFF = mode_reg.slide_sub_disable;

  // ----------------------------------------------------------------
  // Plain stored registers
  // ----------------------------------------------------------------
  logic [9:0] window_reg;
  logic [7:0] crate_reg;

  // Count above 3F0 is the software's fault; stored as written
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      window_reg <= WINDOW_RESET;
    else if (wr_window)
      window_reg <= REG_WDATA[9:0];
  end

  // Crate number feeds every output data word
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      crate_reg <= CRATE_RESET;
    else if (wr_crate)
      crate_reg <= REG_WDATA[7:0];
  end
  assign CRATE_NUM = crate_reg;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Answer one cycle after the read strobe; write-only and unmapped read zero
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
      begin
        case (REG_ADDR)
          ADDR_ABORT_WINDOW: REG_RDATA <= {6'h00, window_reg};
          ADDR_MODE_SET: REG_RDATA <= mode_reg;
          ADDR_CRATE: REG_RDATA <= {8'h00, crate_reg};
          default: REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Readout pointer steps
  // ----------------------------------------------------------------

  // Registered one-cycle pulses to the output buffer
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      PTR_EVENT_STEP <= 1'b0;
      PTR_WORD_STEP <= 1'b0;
    end
    else
    begin
      PTR_EVENT_STEP <= wr_event_step;
      PTR_WORD_STEP <= wr_word_step || (mode_reg.auto_pointer_advance_bit && OBUF_READ);
    end
  end

  // ----------------------------------------------------------------
  // Abort window timer
  // ----------------------------------------------------------------
  logic [17:0] elapsed_reg;
  logic [17:0] elapsed_next;

  assign elapsed_next = elapsed_reg + 18'(CLK_QNS);

  // Exact in quarter ns, so 31.25 ns steps do not drift on a 50 ns clock
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      elapsed_reg <= 18'h00000;
      ABORT_WINDOW_OPEN <= 1'b0;
    end
    else if (ABORT_START)
    begin
      elapsed_reg <= 18'h00000;
      ABORT_WINDOW_OPEN <= 1'b1;
    end
    else if (ABORT_WINDOW_OPEN)
    begin
      elapsed_reg <= elapsed_next;
      if (elapsed_next >= window_qns(window_reg))
        ABORT_WINDOW_OPEN <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion filter, empty events, trigger counting
  // ----------------------------------------------------------------

  // Decisions come out one cycle after their inputs
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      CONV_STORE <= 1'b0;
      EMPTY_EVENT_STORE <= 1'b0;
      EVCNT_INC <= 1'b0;
    end
    else
    begin
      CONV_STORE <= CONV_VALID && !mode_reg.acquisition_test_bit &&
                    accept_conv(mode_reg, CONV_VALUE, CONV_OVERFLOW, CONV_THRESHOLD);
      EMPTY_EVENT_STORE <= EVENT_DONE && !EVENT_HAS_DATA && mode_reg.empty_event_bit;
      EVCNT_INC <= TRIGGER && (mode_reg.count_every_trigger_bit || TRIGGER_ACCEPTED);
    end
  end

  // ----------------------------------------------------------------
  // Memory test writes
  // ----------------------------------------------------------------
  logic [15:0] mt_addr_reg;
  logic [15:0] mt_upper_reg;

  // Address and upper half wait for the lower half
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      mt_addr_reg <= 16'h0000;
      mt_upper_reg <= 16'h0000;
    end
    else
    begin
      if (wr_mt_addr)
        mt_addr_reg <= REG_WDATA;
      if (wr_mt_upper)
        mt_upper_reg <= REG_WDATA;
    end
  end

  // Lower half commits the word, only in memory test mode
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      MEMTEST_WR <= 1'b0;
      MEMTEST <= '0;
    end
    else
    begin
      MEMTEST_WR <= wr_mt_lower && mode_reg.memtest_mode;
      if (wr_mt_lower && mode_reg.memtest_mode)
        MEMTEST <= '{addr: mt_addr_reg, data: {mt_upper_reg, REG_WDATA}};
    end
  end

  // ----------------------------------------------------------------
  // Synthetic event FIFO
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_out_data;

  // Drain only in acquisition test mode; a write into a full FIFO drops
  // the oldest word, so extra words overwrite earlier ones
  assign fifo_pop = (fifo_out_valid && mode_reg.acquisition_test_bit && SYNTH_READY) ||
                    (wr_synth && !fifo_in_ready);
  assign SYNTH_VALID = fifo_out_valid && mode_reg.acquisition_test_bit;
  assign SYNTH_DATA = fifo_out_data;

  synth_event_fifo #(
    .WIDTH(TEST_WORD_W),
    .DEPTH(TEST_FIFO_DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst_n(rst_n_reg),
    .flush(mode_reg.data_flush),
    .in_valid(wr_synth && (fifo_in_ready || fifo_pop)),
    .in_ready(fifo_in_ready),
    .in_data(REG_WDATA),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned win_cnt;
  always_ff @(posedge SYS_CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      win_cnt <= 0;
    else if (ABORT_START)
      win_cnt <= 0;
    else if (ABORT_WINDOW_OPEN)
      win_cnt <= win_cnt + 1;
  end

  event_step_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    wr_event_step |=> PTR_EVENT_STEP)
    else $error("event step pulse missing");

  word_step_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    PTR_WORD_STEP |-> $past(wr_word_step) || $past(OBUF_READ))
    else $error("word step without cause");

  auto_step_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    (OBUF_READ && !mode_reg.auto_pointer_advance_bit && !wr_word_step) |=> !PTR_WORD_STEP)
    else $error("read stepped pointer with auto advance off");

  window_len_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    $fell(ABORT_WINDOW_OPEN) && !$past(ABORT_START) |->
      (win_cnt * CLK_QNS >= window_qns(window_reg)) &&
      ((win_cnt - 1) * CLK_QNS < window_qns(window_reg)))
    else $error("abort window length wrong");

  mode_set_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    wr_set |=> (mode_reg & $past(REG_WDATA)) == $past(REG_WDATA))
    else $error("mode set lost a bit");

  mode_clear_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    wr_clear |=> ((mode_reg & $past(REG_WDATA)) == 16'h0000) &&
                 ((mode_reg | $past(REG_WDATA)) == ($past(mode_reg) | $past(REG_WDATA))))
    else $error("mode clear wrong");

  memtest_gate_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    MEMTEST_WR |-> $past(mode_reg.memtest_mode) && $past(wr_mt_lower))
    else $error("memory test write outside test mode");

  memtest_word_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    MEMTEST_WR |-> MEMTEST.data == {mt_upper_reg, $past(REG_WDATA)})
    else $error("memory test word mismatch");

  empty_event_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    (EVENT_DONE && !EVENT_HAS_DATA && !mode_reg.empty_event_bit) |=> !EMPTY_EVENT_STORE)
    else $error("empty event stored while disabled");

  evcnt_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    (TRIGGER && mode_reg.count_every_trigger_bit) |=> EVCNT_INC)
    else $error("trigger not counted");

  overflow_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    (CONV_VALID && CONV_OVERFLOW && !mode_reg.overrange_check_disable) |=> !CONV_STORE)
    else $error("overflow stored");

  synth_gate_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
    (CONV_VALID && mode_reg.acquisition_test_bit) |=> !CONV_STORE)
    else $error("real conversion stored in acquisition test mode");

endmodule : qdc_readout_mode_test_regs

// ===== qdc_readout_mode_test_regs_tb_top.sv
// Self-checking bench for the readout, mode and test register bank
`timescale 1ns/100ps
module qdc_readout_mode_test_regs_tb_top;
  import qdc_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, rv, obr = 1'b0, ab = 1'b0, cv = 1'b0, ov = 1'b0, dn = 1'b0, hd = 1'b0;
  logic tg = 1'b0, ta = 1'b0, sr = 1'b0;
  logic [15:0] ad, wd, rdat, sd, me, d, r;
  logic [11:0] val = 12'h000;
  logic [7:0] thr = 8'h00, crate;
  logic pe, pw, wo, ce, dr, sh, so, cs, es, ei, mw, sv;
  mode_t mode;
  memtest_wr_t mt;
  logic [15:0] q[$];
  int n_mismatch = 0;
  int checked = 0;
  int n;

  qdc_readout_mode_test_regs dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(ad), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv), .OBUF_READ(obr),
    .PTR_EVENT_STEP(pe), .PTR_WORD_STEP(pw), .ABORT_START(ab), .ABORT_WINDOW_OPEN(wo),
    .MODE(mode), .CONV_ENABLE(ce), .DATA_RESET(dr), .SLIDE_HOLD(sh), .SLIDE_SUB_OFF(so),
    .CONV_VALID(cv), .CONV_VALUE(val), .CONV_OVERFLOW(ov), .CONV_THRESHOLD(thr),
    .CONV_STORE(cs), .EVENT_DONE(dn), .EVENT_HAS_DATA(hd), .EMPTY_EVENT_STORE(es),
    .TRIGGER(tg), .TRIGGER_ACCEPTED(ta), .EVCNT_INC(ei), .MEMTEST_WR(mw), .MEMTEST(mt),
    .CRATE_NUM(crate), .SYNTH_VALID(sv), .SYNTH_READY(sr), .SYNTH_DATA(sd));
  cpu_model cpu (.clk(clk), .wr(wr), .rd(rd), .addr(ad), .wdata(wd), .rdata(rdat),
    .rvalid(rv));

  // ----
  // Expectations and checks
  // ----
  function automatic logic exp_store(logic [15:0] m, logic [11:0] v, logic o, logic [7:0] t);
    exp_store = !m[6] && (m[4] || v >= ({4'h0, t} << (m[8] ? 1 : 4))) && (m[3] || !o);
  endfunction : exp_store

  // Rounded up to whole clock periods, since the window closes on an edge
  function automatic int exp_win(logic [9:0] k);
    exp_win = (WINDOW_BASE_QNS + int'(k) * WINDOW_STEP_QNS + CLK_QNS - 1) / CLK_QNS;
  endfunction : exp_win

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Mode word by read-back and on the derived outputs
  task automatic chk_mode;
    chk(mode, me, "mode");
    chk(ce, !me[1], "online");
    chk(dr, me[2], "flush");
    chk(sh, !me[7], "hold");
    chk(so, me[13], "sub");
    cpu.read(ADDR_MODE_SET, r);
    chk(r, me, "mode rd");
  endtask : chk_mode

  task automatic set_mode(input logic [15:0] a, input logic [15:0] v);
    cpu.write(a, v);
    me = (a == ADDR_MODE_SET) ? (me | v) : (me & ~v);
    #1;
  endtask : set_mode

  // All event-side pulses in one cycle with random qualifiers
  task automatic fire;
    logic [11:0] v;
    logic [7:0] t;
    logic [2:0] b;
    v = 12'($urandom);
    t = 8'($urandom);
    b = 3'($urandom);
    @(posedge clk);
    {cv, dn, tg, obr} <= 4'hF;
    {val, thr, ov, hd, ta} <= {v, t, b};
    @(posedge clk);
    {cv, dn, tg, obr} <= 4'h0;
    #1;
    chk(cs, exp_store(me, v, b[2], t), "store");
    chk(es, me[12] && !b[1], "empty");
    chk(ei, b[0] || me[14], "evcnt");
    chk(pw, me[11], "auto");
  endtask : fire

  always #25 clk = ~clk;

  initial
  begin
    #(50 * 40000);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    void'($urandom(48));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    me = MODE_RESET;
    chk_mode();
    cpu.read(ADDR_MODE_CLEAR, r);
    chk(r, 16'h0000, "wo rd");
    cpu.read(16'h1030, r);
    chk(r, 16'h0000, "unmapped");
    $display("test reset done");
    d = 16'($urandom);
    cpu.write(ADDR_CRATE, d);
    cpu.read(ADDR_CRATE, r);
    chk(r, {8'h00, d[7:0]}, "crate rd");
    chk(crate, d[7:0], "crate");
    $display("test crate done");
    // Reserved bits are never touched by software
    repeat (30)
    begin
      set_mode(($urandom % 2) ? ADDR_MODE_SET : ADDR_MODE_CLEAR, 16'($urandom) & 16'h79DF);
      chk_mode();
      fire();
    end
    set_mode(ADDR_MODE_CLEAR, 16'h0800);
    cpu.write(ADDR_EVENT_STEP, 16'($urandom));
    #1;
    chk({pe, pw}, 2'b10, "ev step");
    cpu.write(ADDR_WORD_STEP, 16'($urandom));
    #1;
    chk({pe, pw}, 2'b01, "wd step");
    fire();
    $display("test modes done");
    set_mode(ADDR_MODE_SET, 16'h0001);
    d = 16'($urandom) & 16'h7FFF;
    cpu.memtest(d, 32'hA5C3_1E0F);
    #1;
    chk({mw, mt}, {1'b1, d, 32'hA5C3_1E0F}, "memtest");
    set_mode(ADDR_MODE_CLEAR, 16'h0001);
    cpu.write(ADDR_MEMTEST_LOWER, 16'h1234);
    #1;
    chk(mw, 1'b0, "memtest off");
    $display("test memtest done");
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h03F0 : 16'($urandom % 16'h03F1);
      cpu.set_window(d[9:0]);
      cpu.read(ADDR_ABORT_WINDOW, r);
      chk(r, d, "window rd");
      @(posedge clk);
      ab <= 1'b1;
      @(posedge clk);
      ab <= 1'b0;
      n = 0;
      #1;
      while (wo === 1'b1 && n < 2000)
      begin
        n++;
        @(posedge clk);
        #1;
      end
      chk(n, exp_win(d[9:0]), "window");
    end
    $display("test window done");
    set_mode(ADDR_MODE_CLEAR, 16'h0004);
    set_mode(ADDR_MODE_SET, 16'h0040);
    // One full event, then one word too many so the oldest is overwritten
    for (int k = TEST_FIFO_DEPTH; k <= TEST_FIFO_DEPTH + 1; k++)
    begin
      repeat (k)
      begin
        d = 16'($urandom) & 16'h1FFF;
        q.push_back(d);
        cpu.write(ADDR_SYNTH_EVENT, d);
      end
      if (k > TEST_FIFO_DEPTH)
        void'(q.pop_front());
      n = 0;
      while (q.size() > 0 && n < 500)
      begin
        @(posedge clk);
        sr <= 1'($urandom);
        n++;
        #1;
        if (sv && sr)
          chk(sd, q.pop_front(), "synth");
      end
      @(posedge clk);
      sr <= 1'b0;
      #1;
      chk({sv, 16'(q.size())}, 17'h0, "synth empty");
    end
    $display("test synth done");
    test_done();
  end
endmodule : qdc_readout_mode_test_regs_tb_top

// ===== qdc_regs_pkg.sv
// Shared constants and types for the readout, mode and test register bank
package qdc_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_EVENT_STEP = 16'h1028;
  localparam logic [15:0] ADDR_WORD_STEP = 16'h102A;
  localparam logic [15:0] ADDR_ABORT_WINDOW = 16'h102E;
  localparam logic [15:0] ADDR_MODE_SET = 16'h1032;
  localparam logic [15:0] ADDR_MODE_CLEAR = 16'h1034;
  localparam logic [15:0] ADDR_MEMTEST_ADDR = 16'h1036;
  localparam logic [15:0] ADDR_MEMTEST_UPPER = 16'h1038;
  localparam logic [15:0] ADDR_MEMTEST_LOWER = 16'h103A;
  localparam logic [15:0] ADDR_CRATE = 16'h103C;
  localparam logic [15:0] ADDR_SYNTH_EVENT = 16'h103E;

  // ----------------------------------------------------------------
  // Reset values and field widths
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_RESET = 16'h4880;
  localparam logic [9:0] WINDOW_RESET = 10'h000;
  localparam logic [7:0] CRATE_RESET = 8'h00;
  localparam logic [9:0] WINDOW_MAX_N = 10'h3F0;
  localparam int TEST_FIFO_DEPTH = 32;
  localparam int TEST_WORD_W = 16;
  localparam int COARSE_SHIFT = 4;
  localparam int FINE_SHIFT = 1;

  // ----------------------------------------------------------------
  // Abort window timing, in quarter nanoseconds to stay exact
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int WINDOW_BASE_NS = 7000;
  localparam int WINDOW_STEP_QNS = 125;
  localparam int CLK_QNS = CLK_PERIOD_NS * 4;
  localparam int WINDOW_BASE_QNS = WINDOW_BASE_NS * 4;

  // ----------------------------------------------------------------
  // Mode word layout, bit 15 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsv15;
    logic count_every_trigger_bit;
    logic slide_sub_disable;
    logic empty_event_bit;
    logic auto_pointer_advance_bit;
    logic [1:0] rsv10_9;
    logic threshold_scale_bit;
    logic slide_enable;
    logic acquisition_test_bit;
    logic rsv5;
    logic threshold_check_disable_bit;
    logic overrange_check_disable;
    logic data_flush;
    logic offline;
    logic memtest_mode;
  } mode_t;

  // Memory test write to the output buffer
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
  } memtest_wr_t;

endpackage : qdc_regs_pkg

// ===== synth_event_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/100ps
module synth_event_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr_reg[AW-1:0]];
  assign pop = out_valid && out_ready;
  // A word may enter a full FIFO in the cycle its head leaves
  assign push = in_valid && (in_ready || pop);

  // Pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else if (flush)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_reg[AW-1:0]] <= in_data;
  end

endmodule : synth_event_fifo
